// *** serial_host_pkg.sv ***
// Constants and types shared by the serial host port
package serial_host_pkg;
   localparam int PAYLOAD_BITS = 8;          // Payload width of one word
   localparam logic [3:0] TAG_BITS_3W = 4'h1; // Leading tag bit count in 3-wire mode
   localparam logic [3:0] WORD_BITS_4W = 4'h8; // Bits per word in 4-wire mode
   localparam logic [3:0] WORD_BITS_3W = 4'h9; // Bits per word in 3-wire mode
   localparam logic MODE_4WIRE = 1'b0;       // Strap low selects 4-wire
   localparam logic MODE_3WIRE = 1'b1;       // Strap high selects 3-wire
   localparam logic TAG_COMMAND = 1'b0;      // Tag value for a command
   localparam logic TAG_DATA = 1'b1;         // Tag value for data
   localparam logic [3:0] BIT_COUNT_RESET = 4'h0; // Bit counter after reset
   localparam logic [7:0] SHIFT_RESET = 8'h00; // Shift register after reset
   localparam logic BUSY_N_RESET = 1'b0;     // Busy shown during reset
   // Receive sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SHIFT = 3'b010,
      ST_READ = 3'b100
   } host_state_t;
endpackage : serial_host_pkg

// *** serial_host_port.sv ***
// Serial host port: 3/4-wire word receiver, read shifter and busy output
`timescale 1ns/1ps
// Functional notes
// - Strap picks 4-wire low, 3-wire high
// - 4-wire: eight bits in, MSB first
// - Finished byte goes to command or data
// - 3-wire: tag bit then eight bits
// - Tag zero is command, one data
// - Busy output shows internal work
// - Busy held low during soft reset
module serial_host_port import serial_host_pkg::*; #(
   parameter int WORD_WIDTH = PAYLOAD_BITS // Payload width; logic serves 8 only
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic hw_reset_n,
   input wire logic iface_mode_strap,
   input wire logic chip_select_n,
   input wire logic serial_clk,
   input wire logic cmd_data_sel,
   input wire logic serial_data_in,
   output logic serial_data_out,
   output logic serial_data_oe,
   output logic [7:0] rx_byte,
   output logic cmd_valid,
   output logic data_valid,
   input wire logic read_req,
   input wire logic [7:0] read_byte,
   input wire logic core_busy,
   input wire logic soft_reset_active,
   output logic busy_n
);
   // Elaboration guard: shifters and counters below are sized for 8-bit payloads only
   if (WORD_WIDTH != 8) begin : g_width_check
      $error("serial_host_port serves only 8-bit words");
   end

   // Registered state with its next values
   host_state_t state, next_state;          // Sequencer state
   logic mode, next_mode;                   // Captured interface mode
   logic [3:0] bit_count, next_bit_count;   // Bits taken in this word
   logic [7:0] shift, next_shift;           // Incoming shift register
   logic tag, next_tag;                     // Command/data tag of the word
   logic sclk_d, next_sclk_d;               // Previous serial clock level
   logic [7:0] rd_shift, next_rd_shift;     // Outgoing read bits
   logic [7:0] next_rx_byte;
   logic next_cmd_valid, next_data_valid;
   logic next_sdo, next_sdo_oe, next_busy_n;
   logic sclk_rise, sclk_fall;              // Serial clock edges in core time
   logic [3:0] word_bits;                   // Length of a word in current mode
   logic rd_msb;                            // Bit the next serial clock fall drives

   // Serial clock edges found by comparing the pin against its last sampled level
   assign sclk_rise = serial_clk & ~sclk_d;
   assign sclk_fall = ~serial_clk & sclk_d;
   assign word_bits = (mode == MODE_3WIRE) ? WORD_BITS_3W : WORD_BITS_4W;
   assign rd_msb = rd_shift[7];

   // Next-state logic for receive, read and busy
   always_comb begin
      next_state = state;
      next_mode = mode;
      next_bit_count = bit_count;
      next_shift = shift;
      next_tag = tag;
      next_sclk_d = serial_clk;
      next_rd_shift = rd_shift;
      next_rx_byte = rx_byte;
      next_cmd_valid = 1'b0;
      next_data_valid = 1'b0;
      next_sdo = serial_data_out;
      next_sdo_oe = serial_data_oe;
      // Busy is low while soft reset runs or core works
      next_busy_n = ~(core_busy | soft_reset_active);
      if (!hw_reset_n) begin
         // Hardware reset pin idles the sequencer, clears the bit count, releases the line and shows busy
         next_state = ST_IDLE;
         next_bit_count = BIT_COUNT_RESET;
         next_sdo_oe = 1'b0;
         next_busy_n = BUSY_N_RESET;
      end else if (chip_select_n) begin
         // Deselect drops any partial word and releases the line
         next_state = ST_IDLE;
         next_bit_count = BIT_COUNT_RESET;
         next_sdo_oe = 1'b0;
         // Mode is latched only between words, so a strap glitch mid-word is harmless
         next_mode = iface_mode_strap;
      end else begin
         case (state)
            ST_IDLE: begin
               // One settling cycle after select; a rise seen here is not taken
               next_state = ST_SHIFT;
               next_bit_count = BIT_COUNT_RESET;
            end
            ST_SHIFT: begin
               if (sclk_rise) begin
                  // In 3-wire the first bit is the tag, not payload
                  if (mode == MODE_3WIRE && bit_count == BIT_COUNT_RESET) begin
                     next_tag = serial_data_in;
                  end else begin
                     next_shift = {shift[6:0], serial_data_in};
                  end
                  if (mode == MODE_4WIRE && bit_count == BIT_COUNT_RESET) begin
                     next_tag = cmd_data_sel;
                  end
                  // The last bit of the word completes the byte
                  if (bit_count + 4'h1 == word_bits) begin
                     next_bit_count = BIT_COUNT_RESET;
                     next_rx_byte = {shift[6:0], serial_data_in};
                     // Route by tag: zero to decoder, one to memory path
                     next_cmd_valid = (next_tag == TAG_COMMAND);
                     next_data_valid = (next_tag == TAG_DATA);
                     // Read byte is loaded on the edge that finishes the command
                     if (read_req && next_tag == TAG_COMMAND) begin
                        next_state = ST_READ;
                        next_rd_shift = read_byte;
                     end
                  end else begin
                     next_bit_count = bit_count + 4'h1;
                  end
               end
            end
            ST_READ: begin
               // Drive on falling edge so host samples on the rise
               // Deselect, not a bit count, ends a read
               if (sclk_fall) begin
                  next_sdo_oe = 1'b1;
                  next_sdo = rd_msb;
                  next_rd_shift = {rd_shift[6:0], 1'b0};
               end
            end
            default: begin
               next_state = ST_IDLE;
            end
         endcase
      end
   end

   // State registers; clock enable freezes everything
   // Async reset loads constants only, so no path from logic into the reset branch
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_IDLE;
         mode <= MODE_4WIRE;
         bit_count <= BIT_COUNT_RESET;
         shift <= SHIFT_RESET;
         tag <= TAG_COMMAND;
         sclk_d <= 1'b0;
         rd_shift <= SHIFT_RESET;
         rx_byte <= SHIFT_RESET;
         cmd_valid <= 1'b0;
         data_valid <= 1'b0;
         serial_data_out <= 1'b0;
         serial_data_oe <= 1'b0;
         busy_n <= BUSY_N_RESET;
      end else if (clk_en) begin
         state <= next_state;
         mode <= next_mode;
         bit_count <= next_bit_count;
         shift <= next_shift;
         tag <= next_tag;
         sclk_d <= next_sclk_d;
         rd_shift <= next_rd_shift;
         rx_byte <= next_rx_byte;
         cmd_valid <= next_cmd_valid;
         data_valid <= next_data_valid;
         serial_data_out <= next_sdo;
         serial_data_oe <= next_sdo_oe;
         busy_n <= next_busy_n;
      end
   end

   // Checks on the design's own outputs and internal state
   a_valid_exclusive: assert property (@(posedge core_clk) disable iff (!nrst)
      !(cmd_valid && data_valid)) else $error("command and data valid together");
   a_soft_reset_busy: assert property (@(posedge core_clk) disable iff (!nrst)
      (clk_en && hw_reset_n && soft_reset_active) |=> !busy_n) else $error("busy high in soft reset");
   a_core_busy: assert property (@(posedge core_clk) disable iff (!nrst)
      (clk_en && core_busy) |=> !busy_n) else $error("busy not shown");
   a_deselect_clears: assert property (@(posedge core_clk) disable iff (!nrst)
      (clk_en && hw_reset_n && chip_select_n) |=> (bit_count == 4'h0 && !serial_data_oe))
      else $error("deselect left word state");
   a_count_bound: assert property (@(posedge core_clk) disable iff (!nrst)
      bit_count < word_bits) else $error("bit counter out of range");
   a_valid_pulse: assert property (@(posedge core_clk) disable iff (!nrst)
      (cmd_valid || data_valid) |=> ((!cmd_valid && !data_valid) || $past(clk_en) == 1'b0))
      else $error("valid longer than one cycle");
   a_valid_at_wrap: assert property (@(posedge core_clk) disable iff (!nrst)
      ($rose(cmd_valid) || $rose(data_valid)) |-> bit_count == 4'h0) else $error("valid without word end");
   a_mode_stable: assert property (@(posedge core_clk) disable iff (!nrst)
      (!chip_select_n && hw_reset_n && state != ST_IDLE) |=> $stable(mode))
      else $error("mode changed mid-word");
   // A hardware reset pulse leaves the port idle, released and busy
   a_hw_reset_idle: assert property (@(posedge core_clk) disable iff (!nrst)
      (clk_en && !hw_reset_n) |=> (state == ST_IDLE && bit_count == 4'h0 && !serial_data_oe && !busy_n))
      else $error("hardware reset left port active");
   // The last bit of a word always delivers the byte one cycle later
   a_word_end_valid: assert property (@(posedge core_clk) disable iff (!nrst)
      (clk_en && hw_reset_n && !chip_select_n && state == ST_SHIFT && sclk_rise
      && bit_count + 4'h1 == word_bits) |=> (cmd_valid || data_valid))
      else $error("finished word not delivered");
   // The leading bit of a 3-wire word becomes the routing tag
   a_tag_capture: assert property (@(posedge core_clk) disable iff (!nrst)
      (clk_en && hw_reset_n && !chip_select_n && state == ST_SHIFT && sclk_rise && mode == MODE_3WIRE
      && bit_count == 4'h0) |=> (tag == $past(serial_data_in))) else $error("tag bit not captured");
   // Each serial clock fall in a read drives the next bit, most significant first
   a_read_drive: assert property (@(posedge core_clk) disable iff (!nrst)
      (clk_en && hw_reset_n && !chip_select_n && state == ST_READ && sclk_fall)
      |=> (serial_data_oe && serial_data_out == $past(rd_msb))) else $error("read bit not driven");
   // Covers for the main scenarios
   c_command: cover property (@(posedge core_clk) disable iff (!nrst) cmd_valid);
   c_data_3wire: cover property (@(posedge core_clk) disable iff (!nrst) data_valid && mode);
   c_read: cover property (@(posedge core_clk) disable iff (!nrst) serial_data_oe);
   c_abort: cover property (@(posedge core_clk) disable iff (!nrst) chip_select_n && state == ST_SHIFT && bit_count != 4'h0);
   c_command_4wire: cover property (@(posedge core_clk) disable iff (!nrst) cmd_valid && !mode);
endmodule : serial_host_port

// *** host_model.sv ***
// Host-side model that clocks words into the serial port and reads bytes back
`timescale 1ns/1ps
module host_model (
   input wire logic core_clk,
   input wire logic serial_data_out,
   input wire logic serial_data_oe,
   output logic chip_select_n,
   output logic serial_clk,
   output logic cmd_data_sel,
   output wire logic serial_data_in,
   output logic iface_mode_strap
);
   logic host_bit = 1'b0; // Level the host drives
   logic [7:0] rd = 8'h00; // Bits sampled back
   // Shared line; a released host toggles so a stale bit never looks valid
   assign serial_data_in = serial_data_oe ? serial_data_out : host_bit;
   initial begin
      chip_select_n = 1'b1;
      serial_clk = 1'b0;
      cmd_data_sel = 1'b0;
      iface_mode_strap = 1'b0;
   end
   task automatic wait_cy(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : wait_cy
   // Each clock phase lasts three core cycles, above the one that is needed
   task automatic clock_bit(input logic b, input logic rel);
      host_bit = rel ? ~host_bit : b;
      wait_cy(3);
      // Host takes a read bit as it raises the clock
      rd = {rd[6:0], serial_data_in};
      serial_clk = 1'b1;
      wait_cy(3);
      serial_clk = 1'b0;
   endtask : clock_bit
   // Strap settles while deselected; nbits below 8 aborts the word
   task automatic word(input logic mode, input logic tag, input logic [7:0] val, input int nbits, input logic hold);
      iface_mode_strap = mode;
      cmd_data_sel = mode ? 1'b0 : tag;
      wait_cy(2);
      chip_select_n = 1'b0;
      wait_cy(2);
      if (mode) clock_bit(tag, 1'b0);
      for (int i = 7; i > 7 - nbits; i--) clock_bit(val[i], 1'b0);
      wait_cy(3);
      if (!hold) chip_select_n = 1'b1;
      wait_cy(3);
   endtask : word
   // Eight released bits, then deselect
   task automatic read_back();
      for (int i = 0; i < 8; i++) clock_bit(1'b0, 1'b1);
      wait_cy(3);
      chip_select_n = 1'b1;
      wait_cy(3);
   endtask : read_back
endmodule : host_model

// *** tb_top.sv ***
// Self-checking bench of the serial host port
`timescale 1ns/1ps
module tb_top import serial_host_pkg::*;;
   logic core_clk = 1'b0, nrst = 1'b0, hw_reset_n = 1'b1, read_req = 1'b0, core_busy = 1'b0, soft_reset_active = 1'b0;
   logic [7:0] read_byte = 8'h00, rx_byte, n_cmd = 8'h00, n_data = 8'h00, last = 8'h00, c0, d0;
   logic csn, sclk, dcs, sdi, strap, sdo, oe, cmd_valid, data_valid, busy_n;
   logic clk_en = 1'b1; // Freezes the port while low
   int err_count = 0, compares = 0;
   always #2 core_clk = ~core_clk;
   host_model host_u (.core_clk(core_clk), .serial_data_out(sdo), .serial_data_oe(oe), .chip_select_n(csn),
      .serial_clk(sclk), .cmd_data_sel(dcs), .serial_data_in(sdi), .iface_mode_strap(strap));
   serial_host_port dut_u (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .hw_reset_n(hw_reset_n),
      .iface_mode_strap(strap), .chip_select_n(csn), .serial_clk(sclk), .cmd_data_sel(dcs), .serial_data_in(sdi),
      .serial_data_out(sdo), .serial_data_oe(oe), .rx_byte(rx_byte), .cmd_valid(cmd_valid),
      .data_valid(data_valid), .read_req(read_req), .read_byte(read_byte), .core_busy(core_busy),
      .soft_reset_active(soft_reset_active), .busy_n(busy_n));
   // Counts one-cycle pulses and keeps the byte seen with them
   always @(posedge core_clk) begin
      if (cmd_valid === 1'b1) n_cmd <= n_cmd + 8'h01;
      if (data_valid === 1'b1) n_data <= n_data + 8'h01;
      if ((cmd_valid | data_valid) === 1'b1) last <= rx_byte;
   end
   task automatic cy(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cy
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // Every mode and tag pair; counters prove the routing
   task automatic t_words();
      for (int i = 0; i < 4; i++) begin
         c0 = n_cmd;
         d0 = n_data;
         host_u.word(i[1], i[0], 8'ha5 ^ 8'(i), 8, 1'b0);
         check("cmd count", {7'h00, i[0] == TAG_COMMAND}, n_cmd - c0);
         check("data count", {7'h00, i[0] == TAG_DATA}, n_data - d0);
         check("rx byte", 8'ha5 ^ 8'(i), last);
      end
      $display("test words done");
   endtask : t_words
   // A half word is dropped and the next word still lines up
   task automatic t_abort();
      d0 = n_data;
      host_u.word(MODE_4WIRE, TAG_DATA, 8'hff, 4, 1'b0);
      host_u.word(MODE_4WIRE, TAG_DATA, 8'h3c, 8, 1'b0);
      check("abort count", 8'h01, n_data - d0);
      check("abort byte", 8'h3c, last);
      $display("test abort done");
   endtask : t_abort
   task automatic t_read();
      read_req = 1'b1;
      read_byte = 8'h96;
      host_u.word(MODE_3WIRE, TAG_COMMAND, 8'h0b, 8, 1'b1);
      read_req = 1'b0;
      host_u.read_back();
      check("read byte", 8'h96, host_u.rd);
      check("oe after deselect", 8'h00, {7'h00, oe});
      $display("test read done");
   endtask : t_read
   task automatic t_busy();
      core_busy = 1'b1;
      cy(3);
      check("busy core", 8'h00, {7'h00, busy_n});
      core_busy = 1'b0;
      soft_reset_active = 1'b1;
      cy(3);
      check("busy soft", 8'h00, {7'h00, busy_n});
      soft_reset_active = 1'b0;
      cy(3);
      check("busy idle", 8'h01, {7'h00, busy_n});
      hw_reset_n = 1'b0;
      cy(2);
      check("busy hw reset", 8'h00, {7'h00, busy_n});
      hw_reset_n = 1'b1;
      cy(3);
      check("busy released", 8'h01, {7'h00, busy_n});
      $display("test busy done");
   endtask : t_busy
   // Clock enable low freezes busy even while the core works
   task automatic t_freeze();
      clk_en = 1'b0;
      core_busy = 1'b1;
      cy(3);
      check("busy frozen", 8'h01, {7'h00, busy_n});
      clk_en = 1'b1;
      cy(2);
      check("busy unfrozen", 8'h00, {7'h00, busy_n});
      core_busy = 1'b0;
      cy(2);
      check("busy after freeze", 8'h01, {7'h00, busy_n});
      $display("test freeze done");
   endtask : t_freeze
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   initial begin
      cy(12);
      nrst = 1'b1;
      cy(2);
      t_busy();
      t_freeze();
      t_words();
      t_abort();
      t_read();
      wrap_up();
   end
   // Tests need about 490 cycles; the limit leaves wide margin
   initial begin
      #40000;
      err_count++;
      wrap_up();
   end
endmodule : tb_top
